// [core/sup_defines.svh]
// Constants for the supervisor two-wire slave
// Functional notes
// - Main supply below first trip threshold clears the main supply fault bit.
// - Second monitor below second trip threshold clears the second monitor fault bit.
// - Device is only a slave; the master starts transfers and drives the clock.
// - Data changes only with clock low; changes with clock high are start or stop.
// - Watch for start continuously and ignore the bus until one is seen.
// - Stop ends the communication; after a read the device goes to standby.
// - Transmitter releases data after eight bits; receiver pulls it low on ninth clock.
// - Acknowledge the slave byte only on matching identifier; acknowledge write bytes.
// - On read send eight bits, sample acknowledge, continue on acknowledge, else stop; the code sends one byte per register read even on acknowledge.
// - Byte write then stop starts the nonvolatile cycle; bus ignored and data floated.
// - No acknowledge for a data byte written into a protected block.
// - Stop mid-byte or before a full acknowledged data byte performs no write.
// - During the write cycle the slave byte is not acknowledged; master polls.
// - Address counter holds last read address plus one for current-address reads.
// - Stop after the word address loads the counter and returns to standby.
// - Sequential reads step the counter per acknowledge and wrap to zero.
// - Slave byte is type 101x, two zero bits, address top bit, direction bit.
// - Control register sits at 1FF and fault register at 0FF in register space.
// - Last slave byte bit is one for read and zero for write.
// - With the write enable latch clear, writes are ignored and data not acknowledged; the code still takes fault register and latch-only control writes.
// - Fault register resets to zero; software sets ones so faults show as zeros.
`ifndef SUP_DEFINES_SVH
`define SUP_DEFINES_SVH

`define SUP_CLK_PERIOD_NS   50
`define SUP_WRITE_CYCLE_NS  5000000
`define SUP_WRITE_CYCLE_CYC (`SUP_WRITE_CYCLE_NS / `SUP_CLK_PERIOD_NS)
`define SUP_BUSY_W          17

`define SUP_DEV_TYPE        3'h5
`define SUP_SEL_BITS        2'h0
`define SUP_CTL_ADDR        9'h1ff
`define SUP_FAULT_ADDR      9'h0ff
`define SUP_PROT_BASE       9'h100

`define SUP_CTL_RST         8'h61
`define SUP_FAULT_RST       8'h00
`define SUP_CTL_NV_MASK     8'hf1
`define SUP_CTL_LATCH_MASK  8'h06
`define SUP_FAULT_MASK      8'hd0

`define SUP_CTL_BLOCK_LOCK  4
`define SUP_CTL_REG_WEN     2
`define SUP_CTL_WEN_LATCH   1
`define SUP_FLT_MAIN        7
`define SUP_FLT_SECOND      6

`endif

// [core/sup_pkg.sv]
// Types for the supervisor two-wire slave
`include "sup_defines.svh"
package sup_pkg;
    typedef enum logic [3:0] {
        st_idle  = 4'h0,
        st_dev   = 4'h1,
        st_word  = 4'h2,
        st_data  = 4'h3,
        st_ack   = 4'h4,
        st_tx    = 4'h5,
        st_txack = 4'h6,
        st_wait  = 4'h7
    } bus_state_t;

    typedef struct packed {
        logic                   scl_s1;
        logic                   scl_s2;
        logic                   scl_p;
        logic                   sda_s1;
        logic                   sda_s2;
        logic                   sda_p;
        logic                   mon1_s1;
        logic                   mon1_s2;
        logic                   mon2_s1;
        logic                   mon2_s2;
        bus_state_t             fsm;
        bus_state_t             nxt;
        logic [3:0]             cnt;
        logic [7:0]             sh;
        logic                   drive;
        logic                   space;
        logic                   amsb;
        logic                   ack_in;
        logic                   wr_pend;
        logic [7:0]             wdata;
        logic [8:0]             ptr;
        logic [7:0]             ctl;
        logic [7:0]             fault;
        logic [`SUP_BUSY_W-1:0] busy;
    } slave_state_t;
endpackage

// [core/supervisor_two_wire_slave.sv]
// Two-wire slave of the voltage supervisor: registers, array and fault flags
`timescale 1ns/1ps
`include "sup_defines.svh"
module supervisor_two_wire_slave #(
    parameter logic [`SUP_BUSY_W-1:0] WRITE_CYCLE_CYC = `SUP_BUSY_W'(`SUP_WRITE_CYCLE_CYC)
) (
    input  wire logic       i_clk,
    input  wire logic       i_sys_rst,
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    input  wire logic       i_main_supply_low,
    input  wire logic       i_second_monitor_low,
    output logic            o_sda_out,
    output logic            o_sda_oe,
    output logic            o_write_busy,
    output logic [7:0]      o_supervisor_control,
    output logic [7:0]      o_fault_cause_flags
);
    sup_pkg::slave_state_t st_q;
    sup_pkg::slave_state_t st_d;
    logic [7:0]            nv_array [0:511];
    logic                  mem_we;
    logic [7:0]            rdata;
    logic                  wr_ok;
    logic                  rise;
    logic                  fall;
    logic                  start_ev;
    logic                  stop_ev;
    logic                  busy;
    logic                  clean_fall;

    // Edges come from second stage and its delayed copy only
    assign rise     = st_q.scl_s2 & ~st_q.scl_p;
    assign fall     = ~st_q.scl_s2 & st_q.scl_p;
    assign start_ev = st_q.scl_s2 & st_q.scl_p & st_q.sda_p & ~st_q.sda_s2;
    assign stop_ev  = st_q.scl_s2 & st_q.scl_p & ~st_q.sda_p & st_q.sda_s2;
    assign busy     = (st_q.busy != '0);
    // Bus fall that no start, stop or write cycle overrides
    assign clean_fall = fall & ~busy & ~start_ev & ~stop_ev;

    // Open drain: the pad only ever pulls low
    assign o_sda_out            = 1'b0;
    assign o_sda_oe             = st_q.drive;
    assign o_write_busy         = busy;
    assign o_supervisor_control = st_q.ctl;
    assign o_fault_cause_flags  = st_q.fault;

    always_comb begin
        rdata = 8'h00;
        if (!st_q.space) begin
            rdata = nv_array[st_q.ptr];
        end else if (st_q.ptr == `SUP_CTL_ADDR) begin
            rdata = st_q.ctl;
        end else if (st_q.ptr == `SUP_FAULT_ADDR) begin
            rdata = st_q.fault;
        end
    end

    // Acceptance of a received data byte
    always_comb begin
        wr_ok = 1'b0;
        if (!st_q.space) begin
            wr_ok = st_q.ctl[`SUP_CTL_WEN_LATCH]
                    && !(st_q.ctl[`SUP_CTL_BLOCK_LOCK] && st_q.ptr >= `SUP_PROT_BASE);
        end else if (st_q.wr_pend) begin
            wr_ok = 1'b0;
        end else if (st_q.ptr == `SUP_CTL_ADDR) begin
            // Latch-only values must pass, otherwise the latch could never be set
            wr_ok = st_q.ctl[`SUP_CTL_WEN_LATCH] || ((st_q.sh & ~`SUP_CTL_LATCH_MASK) == 8'h00);
        end else if (st_q.ptr == `SUP_FAULT_ADDR) begin
            wr_ok = 1'b1;
        end
    end

    always_comb begin
        st_d        = st_q;
        mem_we      = 1'b0;
        st_d.scl_s1 = i_scl;
        st_d.scl_s2 = st_q.scl_s1;
        st_d.scl_p  = st_q.scl_s2;
        st_d.sda_s1 = i_sda;
        st_d.sda_s2 = st_q.sda_s1;
        st_d.sda_p  = st_q.sda_s2;
        st_d.mon1_s1 = i_main_supply_low;
        st_d.mon1_s2 = st_q.mon1_s1;
        st_d.mon2_s1 = i_second_monitor_low;
        st_d.mon2_s2 = st_q.mon2_s1;
        if (busy) begin
            st_d.busy = st_q.busy - 1'b1;
        end
        if (busy) begin
            // Inputs disabled: nothing acknowledged, line floated
            st_d.fsm   = sup_pkg::st_idle;
            st_d.drive = 1'b0;
        end else if (start_ev) begin
            st_d.fsm   = sup_pkg::st_dev;
            st_d.cnt   = 4'h0;
            st_d.drive = 1'b0;
        end else if (stop_ev) begin
            if (st_q.fsm == sup_pkg::st_data && st_q.wr_pend && st_q.cnt == 4'h1) begin
                if (!st_q.space) begin
                    mem_we    = 1'b1;
                    st_d.busy = WRITE_CYCLE_CYC;
                end else if (st_q.ptr == `SUP_CTL_ADDR) begin
                    if (st_q.ctl[`SUP_CTL_REG_WEN] && st_q.wdata[`SUP_CTL_WEN_LATCH]
                        && !st_q.wdata[`SUP_CTL_REG_WEN]) begin
                        st_d.ctl  = (st_q.wdata & `SUP_CTL_NV_MASK) | 8'h02;
                        st_d.busy = WRITE_CYCLE_CYC;
                    end else if ((st_q.wdata & ~`SUP_CTL_LATCH_MASK) == 8'h00) begin
                        // Volatile latch write, ready again at once
                        st_d.ctl[`SUP_CTL_WEN_LATCH] = st_q.wdata[`SUP_CTL_WEN_LATCH];
                        st_d.ctl[`SUP_CTL_REG_WEN]   = st_q.ctl[`SUP_CTL_REG_WEN]
                            | (st_q.wdata[`SUP_CTL_REG_WEN] & st_q.wdata[`SUP_CTL_WEN_LATCH]);
                    end
                end else begin
                    st_d.fault = st_q.wdata & `SUP_FAULT_MASK;
                end
            end
            st_d.fsm     = sup_pkg::st_idle;
            st_d.drive   = 1'b0;
            st_d.wr_pend = 1'b0;
        end else if (rise) begin
            case (st_q.fsm)
                sup_pkg::st_dev, sup_pkg::st_word, sup_pkg::st_data: begin
                    st_d.sh  = {st_q.sh[6:0], st_q.sda_s2};
                    st_d.cnt = st_q.cnt + 4'h1;
                end
                sup_pkg::st_tx: begin
                    st_d.cnt = st_q.cnt + 4'h1;
                end
                sup_pkg::st_txack: begin
                    st_d.ack_in = ~st_q.sda_s2;
                end
                default: begin
                end
            endcase
        end else if (fall) begin
            case (st_q.fsm)
                sup_pkg::st_dev: begin
                    if (st_q.cnt == 4'h8) begin
                        if (st_q.sh[7:5] == `SUP_DEV_TYPE && st_q.sh[3:2] == `SUP_SEL_BITS) begin
                            st_d.space = st_q.sh[4];
                            st_d.amsb  = st_q.sh[1];
                            st_d.drive = 1'b1;
                            st_d.nxt   = st_q.sh[0] ? sup_pkg::st_tx : sup_pkg::st_word;
                            st_d.fsm   = sup_pkg::st_ack;
                        end else begin
                            st_d.fsm = sup_pkg::st_idle;
                        end
                    end
                end
                sup_pkg::st_word: begin
                    if (st_q.cnt == 4'h8) begin
                        st_d.ptr     = {st_q.amsb, st_q.sh};
                        st_d.drive   = 1'b1;
                        st_d.nxt     = sup_pkg::st_data;
                        st_d.fsm     = sup_pkg::st_ack;
                        st_d.wr_pend = 1'b0;
                    end
                end
                sup_pkg::st_data: begin
                    if (st_q.cnt == 4'h8) begin
                        if (wr_ok) begin
                            st_d.drive   = 1'b1;
                            st_d.wr_pend = 1'b1;
                            st_d.wdata   = st_q.sh;
                            st_d.nxt     = sup_pkg::st_data;
                            st_d.fsm     = sup_pkg::st_ack;
                        end else begin
                            // A refused array write with the latch set also drops the register write enable
                            if (!st_q.space && st_q.ctl[`SUP_CTL_WEN_LATCH]) begin
                                st_d.ctl[`SUP_CTL_REG_WEN] = 1'b0;
                            end
                            st_d.wr_pend = 1'b0;
                            st_d.fsm     = sup_pkg::st_wait;
                        end
                    end
                end
                sup_pkg::st_ack: begin
                    st_d.drive = 1'b0;
                    st_d.cnt   = 4'h0;
                    st_d.fsm   = st_q.nxt;
                    if (st_q.nxt == sup_pkg::st_tx) begin
                        st_d.sh    = rdata;
                        st_d.drive = ~rdata[7];
                    end
                end
                sup_pkg::st_tx: begin
                    if (st_q.cnt == 4'h8) begin
                        st_d.drive  = 1'b0;
                        st_d.ack_in = 1'b0;
                        st_d.fsm    = sup_pkg::st_txack;
                        if (!st_q.space) begin
                            st_d.ptr = st_q.ptr + 9'h001;
                        end
                    end else begin
                        st_d.sh    = {st_q.sh[6:0], 1'b0};
                        st_d.drive = ~st_q.sh[6];
                    end
                end
                sup_pkg::st_txack: begin
                    // Registers give one byte per read
                    if (st_q.ack_in && !st_q.space) begin
                        st_d.sh    = rdata;
                        st_d.drive = ~rdata[7];
                        st_d.cnt   = 4'h0;
                        st_d.fsm   = sup_pkg::st_tx;
                    end else begin
                        st_d.fsm = sup_pkg::st_wait;
                    end
                end
                default: begin
                end
            endcase
        end
        // Monitor clears win over a software write in the same cycle
        if (st_q.mon1_s2) begin
            st_d.fault[`SUP_FLT_MAIN] = 1'b0;
        end
        if (st_q.mon2_s2) begin
            st_d.fault[`SUP_FLT_SECOND] = 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            st_q       <= '0;
            st_q.ctl   <= `SUP_CTL_RST;
            st_q.fault <= `SUP_FAULT_RST;
            // Bus idles high; a low reset value would fake an edge after release
            st_q.scl_s1 <= 1'b1;
            st_q.scl_s2 <= 1'b1;
            st_q.scl_p  <= 1'b1;
            st_q.sda_s1 <= 1'b1;
            st_q.sda_s2 <= 1'b1;
            st_q.sda_p  <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // Array contents survive reset, as nonvolatile storage would
    always_ff @(posedge i_clk) begin
        if (mem_we) begin
            nv_array[st_q.ptr] <= st_q.wdata;
        end
    end

    main_clear_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        st_q.mon1_s2 |=> !st_q.fault[`SUP_FLT_MAIN])
        else $error("main supply fault bit not cleared");

    second_clear_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        st_q.mon2_s2 |=> !st_q.fault[`SUP_FLT_SECOND])
        else $error("second monitor fault bit not cleared");

    drive_low_scl_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        $rose(st_q.drive) |-> !st_q.scl_p)
        else $error("data line pulled while clock high");

    idle_quiet_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        st_q.fsm == sup_pkg::st_idle |-> !st_q.drive)
        else $error("line driven while idle");

    stop_ends_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (stop_ev && !start_ev) |=> st_q.fsm == sup_pkg::st_idle && !st_q.drive)
        else $error("stop did not end the transfer");

    addr_nack_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (!busy && !start_ev && !stop_ev && fall && st_q.fsm == sup_pkg::st_dev && st_q.cnt == 4'h8
         && st_q.sh[7:5] != `SUP_DEV_TYPE) |=> !st_q.drive && st_q.fsm == sup_pkg::st_idle)
        else $error("foreign slave byte acknowledged");

    latch_block_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (!busy && !start_ev && !stop_ev && fall && st_q.fsm == sup_pkg::st_data && st_q.cnt == 4'h8
         && !st_q.space && !st_q.ctl[`SUP_CTL_WEN_LATCH]) |=> !st_q.drive)
        else $error("data acknowledged with latch clear");

    commit_busy_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        mem_we |=> busy ##1 (busy && !st_q.drive)[*3])
        else $error("array write without busy cycle");

    busy_nack_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        busy |-> !st_q.drive)
        else $error("bus driven during write cycle");

    seq_step_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (!busy && !start_ev && !stop_ev && fall && st_q.fsm == sup_pkg::st_tx && st_q.cnt == 4'h8
         && !st_q.space) |=> st_q.ptr == $past(st_q.ptr) + 9'h001)
        else $error("address counter did not step");

    fault_reset_a: assert property (@(posedge i_clk)
        i_sys_rst |=> st_q.fault == 8'h00)
        else $error("fault register not zero after reset");

    start_entry_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (start_ev && !busy) |=> st_q.fsm == sup_pkg::st_dev && st_q.cnt == 4'h0 && !st_q.drive)
        else $error("start did not open a slave byte");

    slave_ack_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (clean_fall && st_q.fsm == sup_pkg::st_dev && st_q.cnt == 4'h8 && st_q.sh[7:5] == `SUP_DEV_TYPE
         && st_q.sh[3:2] == `SUP_SEL_BITS) |=> st_q.drive && st_q.space == $past(st_q.sh[4]))
        else $error("matching slave byte not acknowledged");

    read_dir_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (clean_fall && st_q.fsm == sup_pkg::st_dev && st_q.cnt == 4'h8 && st_q.sh[7:5] == `SUP_DEV_TYPE
         && st_q.sh[3:2] == `SUP_SEL_BITS) |=> (st_q.nxt == sup_pkg::st_tx) == $past(st_q.sh[0]))
        else $error("direction bit misread");

    word_load_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (clean_fall && st_q.fsm == sup_pkg::st_word && st_q.cnt == 4'h8)
        |=> st_q.drive && st_q.ptr == {$past(st_q.amsb), $past(st_q.sh)})
        else $error("word address not loaded and acknowledged");

    ack_release_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (clean_fall && st_q.fsm == sup_pkg::st_ack && st_q.nxt != sup_pkg::st_tx) |=> !st_q.drive)
        else $error("acknowledge held past the ninth clock");

    tx_release_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (clean_fall && st_q.fsm == sup_pkg::st_tx && st_q.cnt == 4'h8)
        |=> !st_q.drive && st_q.fsm == sup_pkg::st_txack)
        else $error("line not released after eight bits");

    nack_cease_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (clean_fall && st_q.fsm == sup_pkg::st_txack && !st_q.ack_in) |=> st_q.fsm == sup_pkg::st_wait)
        else $error("output continued without acknowledge");

    wait_quiet_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        st_q.fsm == sup_pkg::st_wait |-> !st_q.drive)
        else $error("line driven after transfer ended");

    reg_single_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (clean_fall && st_q.fsm == sup_pkg::st_txack && st_q.space) |=> st_q.fsm == sup_pkg::st_wait)
        else $error("register read went past one byte");

    prot_nack_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (clean_fall && st_q.fsm == sup_pkg::st_data && st_q.cnt == 4'h8 && !st_q.space
         && st_q.ctl[`SUP_CTL_BLOCK_LOCK] && st_q.ptr >= `SUP_PROT_BASE) |=> !st_q.drive)
        else $error("protected block write acknowledged");

    abort_nowrite_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        (stop_ev && !busy && (st_q.fsm != sup_pkg::st_data || st_q.cnt != 4'h1)) |=> !busy)
        else $error("aborted write started a write cycle");

    busy_ignore_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
        busy |=> st_q.fsm == sup_pkg::st_idle)
        else $error("bus not ignored during write cycle");

endmodule // supervisor_two_wire_slave

// [verification/two_wire_master_model.sv]
// Behavioural two-wire bus master that drives the slave's bus pins
`timescale 1ns/1ps
module two_wire_master_model (
    input  wire logic i_dev_oe,
    output logic      o_scl,
    output logic      o_sda
);
    logic scl_q = 1'b1;
    logic sda_q = 1'b1;

    // Pulled-up wire: low whenever either party pulls it
    assign o_scl = scl_q;
    assign o_sda = sda_q & ~i_dev_oe;

    // Data moves at mid-low only; clock stands still between frames
    task automatic put_bit(input logic b);
        #100 sda_q = b;
        #100 scl_q = 1'b1;
        #200 scl_q = 1'b0;
    endtask

    task automatic get_bit(output logic b);
        #100 sda_q = 1'b1;
        #100 scl_q = 1'b1;
        #100 b = o_sda;
        #100 scl_q = 1'b0;
    endtask

    task automatic start_c;
        #100 sda_q = 1'b1;
        #100 scl_q = 1'b1;
        #100 sda_q = 1'b0;
        #100 scl_q = 1'b0;
    endtask

    // Slave has let go of the line by the time the clock rises
    task automatic stop_c;
        #100 sda_q = 1'b0;
        #100 scl_q = 1'b1;
        #100 sda_q = 1'b1;
        #100;
    endtask

    task automatic wr_byte(input logic [7:0] v, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) put_bit(v[i]);
        get_bit(b);
        ack = ~b;
    endtask

    // A high ninth bit ends a read before the stop
    task automatic rd_byte(output logic [7:0] v, input logic ack);
        for (int i = 7; i >= 0; i--) get_bit(v[i]);
        put_bit(~ack);
    endtask
endmodule // two_wire_master_model

// [verification/supervisor_two_wire_slave_test.sv]
// Self-checking bench for the supervisor two-wire slave
`timescale 1ns/1ps
`include "sup_defines.svh"
module supervisor_two_wire_slave_test;
    // Short write cycle, still longer than one polling transfer
    localparam int WCYC = 200;
    logic       i_clk                = 1'b0;
    logic       i_sys_rst            = 1'b1;
    logic       i_main_supply_low    = 1'b0;
    logic       i_second_monitor_low = 1'b0;
    wire logic  scl;
    wire logic  sda;
    logic       sda_out;
    logic       o_sda_oe;
    logic       o_write_busy;
    logic [7:0] o_supervisor_control;
    logic [7:0] o_fault_cause_flags;
    logic [7:0] ws[4] = '{8'ha0, 8'ha0, 8'ha2, 8'ha0};
    logic [7:0] ww[4] = '{8'h10, 8'h11, 8'hff, 8'h00};
    logic [7:0] wd[4] = '{8'h5a, 8'hc3, 8'h77, 8'h3c};
    int         fails     = 0;
    int         cmp_count = 0;
    int         cyc       = 0;

    two_wire_master_model m (.i_dev_oe(o_sda_oe), .o_scl(scl), .o_sda(sda));

    supervisor_two_wire_slave #(.WRITE_CYCLE_CYC(`SUP_BUSY_W'(WCYC))) dut (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_scl(scl), .i_sda(sda),
        .i_main_supply_low(i_main_supply_low), .i_second_monitor_low(i_second_monitor_low),
        .o_sda_out(sda_out), .o_sda_oe(o_sda_oe), .o_write_busy(o_write_busy),
        .o_supervisor_control(o_supervisor_control), .o_fault_cause_flags(o_fault_cause_flags)
    );

    always #25 i_clk = ~i_clk;

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            fails++;
            $display("[FAIL] %0t: run limit reached", $time);
            close_out();
        end
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Let the synchroniser catch up with the last bus event
    task automatic settle;
        repeat (4) @(posedge i_clk);
        #1;
    endtask

    task automatic wait_free;
        int n;
        n = 0;
        settle();
        while (o_write_busy !== 1'b0 && n < 400) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        check({7'h00, o_write_busy}, 8'h00);
    endtask

    task automatic xfer_w(input logic [7:0] s, input logic [7:0] w, input logic [7:0] d, output logic ok);
        logic a0, a1, a2;
        m.start_c();
        m.wr_byte(s, a0);
        m.wr_byte(w, a1);
        m.wr_byte(d, a2);
        m.stop_c();
        ok = a0 & a1 & a2;
    endtask

    // Dummy write of the word address, then repeated start for reading
    task automatic rnd(input logic [7:0] s, input logic [7:0] w, output logic ok);
        logic a0, a1, a2;
        m.start_c();
        m.wr_byte(s, a0);
        m.wr_byte(w, a1);
        m.start_c();
        m.wr_byte(s | 8'h01, a2);
        ok = a0 & a1 & a2;
    endtask

    task automatic rd_chk(input logic [7:0] exp, input logic ack);
        logic [7:0] v;
        m.rd_byte(v, ack);
        check(v, exp);
    endtask

    task automatic cur_rd(input logic [7:0] exp);
        logic a;
        m.start_c();
        m.wr_byte(8'ha1, a);
        rd_chk(exp, 1'b0);
        m.stop_c();
    endtask

    task automatic poll(input logic exp);
        logic a;
        m.start_c();
        m.wr_byte(8'ha0, a);
        m.stop_c();
        check({7'h00, a}, {7'h00, exp});
    endtask

    initial begin
        logic ok;
        repeat (12) @(posedge i_clk);
        #1 i_sys_rst = 1'b0;
        repeat (6) @(posedge i_clk);
        #1;
        check(o_supervisor_control, 8'h61);
        check(o_fault_cause_flags, 8'h00);
        check({5'h00, sda_out, o_sda_oe, o_write_busy}, 8'h00);
        xfer_w(8'h90, 8'h10, 8'h5a, ok);
        check({7'h00, ok}, 8'h00);
        xfer_w(8'ha8, 8'h10, 8'h5a, ok);
        check({7'h00, ok}, 8'h00);
        xfer_w(8'ha0, 8'h10, 8'h5a, ok);
        check({7'h00, ok}, 8'h00);
        xfer_w(8'hb2, 8'hff, 8'h02, ok);
        settle();
        check({7'h00, ok}, 8'h01);
        check({o_supervisor_control[7:1], o_write_busy}, 8'h62);
        for (int i = 0; i < 4; i++) begin
            xfer_w(ws[i], ww[i], wd[i], ok);
            check({7'h00, ok}, 8'h01);
            settle();
            check({7'h00, o_write_busy}, 8'h01);
            poll(1'b0);
            wait_free();
            poll(1'b1);
        end
        rnd(8'ha0, 8'h10, ok);
        check({7'h00, ok}, 8'h01);
        rd_chk(8'h5a, 1'b1);
        rd_chk(8'hc3, 1'b0);
        m.stop_c();
        settle();
        check({7'h00, o_sda_oe}, 8'h00);
        rnd(8'ha2, 8'hff, ok);
        rd_chk(8'h77, 1'b1);
        rd_chk(8'h3c, 1'b0);
        m.stop_c();
        m.start_c();
        m.wr_byte(8'ha0, ok);
        m.wr_byte(8'h10, ok);
        m.stop_c();
        cur_rd(8'h5a);
        cur_rd(8'hc3);
        // Abort inside the data byte
        m.start_c();
        m.wr_byte(8'ha0, ok);
        m.wr_byte(8'h10, ok);
        for (int i = 0; i < 4; i++) m.put_bit(1'b0);
        m.stop_c();
        settle();
        check({7'h00, o_write_busy}, 8'h00);
        rnd(8'ha0, 8'h10, ok);
        rd_chk(8'h5a, 1'b0);
        m.stop_c();
        xfer_w(8'hb0, 8'hff, 8'hff, ok);
        settle();
        check(o_fault_cause_flags, 8'hd0);
        i_main_supply_low = 1'b1;
        settle();
        check(o_fault_cause_flags, 8'h50);
        i_second_monitor_low = 1'b1;
        settle();
        check(o_fault_cause_flags, 8'h10);
        i_main_supply_low = 1'b0;
        i_second_monitor_low = 1'b0;
        rnd(8'hb0, 8'hff, ok);
        rd_chk(8'h10, 1'b0);
        m.stop_c();
        xfer_w(8'hb2, 8'hff, 8'h06, ok);
        settle();
        check(o_supervisor_control, 8'h67);
        xfer_w(8'hb2, 8'hff, 8'h13, ok);
        wait_free();
        check(o_supervisor_control, 8'h13);
        rnd(8'hb2, 8'hff, ok);
        rd_chk(8'h13, 1'b0);
        m.stop_c();
        xfer_w(8'ha2, 8'h20, 8'haa, ok);
        settle();
        check({6'h00, ok, o_write_busy}, 8'h00);
        close_out();
    end
endmodule // supervisor_two_wire_slave_test
